// File: hw/aps_pkg.sv
// Shared constants for the arbitrary pulse segment register bank.
package aps_pkg;

    // Bank geometry: channels, segments per channel and segment field widths.
    localparam int unsigned APS_NUM_CH = 14;
    localparam int unsigned APS_SEG_COUNT = 8;
    localparam int unsigned APS_SEG_W = 7;
    localparam int unsigned APS_MAG_W = 6;
    localparam int unsigned APS_HALF_SEGS = 4;
    localparam int unsigned APS_SIGN_BIT = 6;

    // Segment roles inside a channel's pulse.
    localparam int unsigned APS_OVERSHOOT_SEG = 0;
    localparam int unsigned APS_UNDERSHOOT_SEG = 4;
    localparam int unsigned APS_UPPER_FIRST = 0;
    localparam int unsigned APS_LOWER_FIRST = 4;

    // Register indices of channel 0; byte address is four times the index.
    localparam logic [7:0] APS_IDX_SEG_ONE = 8'h08;
    localparam logic [7:0] APS_IDX_SEG_TWO = 8'h09;
    localparam logic [7:0] APS_IDX_SEG_THREE = 8'h0a;
    localparam logic [7:0] APS_IDX_SEG_FOUR = 8'h0b;
    localparam logic [7:0] APS_IDX_SEG_FIVE = 8'h0c;
    localparam logic [7:0] APS_IDX_SEG_SIX = 8'h0d;
    localparam logic [7:0] APS_IDX_SEG_SEVEN = 8'h0e;
    localparam logic [7:0] APS_IDX_SEG_EIGHT = 8'h0f;
    localparam logic [7:0] APS_CH_STRIDE = 8'h10;

    // Address decode: word index position and the span of haddr that is decoded.
    localparam int unsigned APS_IDX_LSB = 2;
    localparam int unsigned APS_IDX_W = 8;
    localparam int unsigned APS_CH_W = 4;
    localparam int unsigned APS_DEC_W = 10;

    // Reset values.
    localparam logic [6:0] APS_SEG_RESET = 7'h00;
    localparam logic [31:0] APS_RDATA_RESET = 32'h0000_0000;

    // AHB-Lite transfer types and response.
    localparam logic [1:0] APS_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] APS_HTRANS_NONSEQ = 2'h2;
    localparam logic APS_HRESP_OKAY = 1'b0;

endpackage : aps_pkg

// File: hw/aps_chan_regs.sv
// One channel's eight segment value registers with a single write port.
`timescale 1ns/1ps
module aps_chan_regs
    import aps_pkg::*;
#(
    parameter int unsigned NUM_SEG = APS_SEG_COUNT,
    parameter int unsigned SEG_W = APS_SEG_W,
    parameter int unsigned SEL_W = $clog2(NUM_SEG)
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Write port from the bus slave.
    input wire logic wr_en,
    input wire logic [SEL_W-1:0] wr_seg,
    input wire logic [SEG_W-1:0] wr_data,
    // Stored segment values, segment 0 in the low bits.
    output logic [NUM_SEG*SEG_W-1:0] seg_values
);

    typedef struct packed {
        logic [NUM_SEG-1:0][SEG_W-1:0] seg;
    } aps_chan_state_t;

    aps_chan_state_t state_ff;
    aps_chan_state_t nxt_state;

    // Only the addressed segment changes; the other seven keep their value.
    always_comb begin
        nxt_state = state_ff;
        if (wr_en) begin
            nxt_state.seg[wr_seg] = wr_data;
        end
    end

    // Every segment clears on reset so the pulse starts from a flat line.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= {NUM_SEG{APS_SEG_RESET}};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign seg_values = state_ff.seg;

endmodule : aps_chan_regs

// File: hw/aps_seg_shape.sv
// Splits one channel's segment values into the roles the line driver uses.
`timescale 1ns/1ps
module aps_seg_shape
    import aps_pkg::*;
#(
    parameter int unsigned NUM_SEG = APS_SEG_COUNT,
    parameter int unsigned SEG_W = APS_SEG_W,
    parameter int unsigned HALF = APS_HALF_SEGS
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Stored segment values of one channel.
    input wire logic [NUM_SEG*SEG_W-1:0] seg_values,
    // Shaped outputs, all registered.
    output logic [SEG_W-1:0] overshoot,
    output logic [SEG_W-1:0] undershoot,
    output logic [HALF*SEG_W-1:0] upper_half,
    output logic [HALF*SEG_W-1:0] lower_half,
    output logic [NUM_SEG-1:0] step_positive,
    output logic [NUM_SEG*(SEG_W-1)-1:0] step_magnitude
);

    typedef struct packed {
        logic [SEG_W-1:0] over;
        logic [SEG_W-1:0] under;
        logic [HALF*SEG_W-1:0] upper;
        logic [HALF*SEG_W-1:0] lower;
        logic [NUM_SEG-1:0] pos;
        logic [NUM_SEG*(SEG_W-1)-1:0] mag;
    } aps_shape_state_t;

    aps_shape_state_t state_ff;
    aps_shape_state_t nxt_state;

    // Role mapping and sign split of every segment.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.over = seg_values[APS_OVERSHOOT_SEG*SEG_W +: SEG_W];
        nxt_state.under = seg_values[APS_UNDERSHOOT_SEG*SEG_W +: SEG_W];
        nxt_state.upper = seg_values[APS_UPPER_FIRST*SEG_W +: HALF*SEG_W];
        nxt_state.lower = seg_values[APS_LOWER_FIRST*SEG_W +: HALF*SEG_W];
        for (int s = 0; s < NUM_SEG; s++) begin
            // Sign bit clear is a negative step, set is a positive step.
            nxt_state.pos[s] = seg_values[s*SEG_W + APS_SIGN_BIT];
            nxt_state.mag[s*(SEG_W-1) +: SEG_W-1] = seg_values[s*SEG_W +: SEG_W-1];
        end
    end

    // Registered so the driver sees clean levels from a flop.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign overshoot = state_ff.over;
    assign undershoot = state_ff.under;
    assign upper_half = state_ff.upper;
    assign lower_half = state_ff.lower;
    assign step_positive = state_ff.pos;
    assign step_magnitude = state_ff.mag;

endmodule : aps_seg_shape

// File: hw/aps_pulse_seg_top.sv
// Top of the arbitrary pulse segment bank: AHB-Lite slave, channel registers, shaping.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module aps_pulse_seg_top
    import aps_pkg::*;
#(
    parameter int unsigned NUM_CH = APS_NUM_CH,
    parameter int unsigned NUM_SEG = APS_SEG_COUNT,
    parameter int unsigned SEG_W = APS_SEG_W,
    parameter int unsigned HALF = APS_HALF_SEGS
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,

    // AHB-Lite address phase.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [2:0] hburst,
    input wire logic [3:0] hprot,
    input wire logic hmastlock,
    input wire logic hready,

    // AHB-Lite data phase and response.
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,

    // Raw segment values, channel-major, segment 0 lowest in each channel.
    output logic [NUM_CH*NUM_SEG*SEG_W-1:0] seg_level,

    // Per-channel pulse roles for the line driver.
    output logic [NUM_CH*SEG_W-1:0] overshoot_level,
    output logic [NUM_CH*SEG_W-1:0] undershoot_level,
    output logic [NUM_CH*HALF*SEG_W-1:0] upper_half_level,
    output logic [NUM_CH*HALF*SEG_W-1:0] lower_half_level,

    // Per-segment direction and magnitude.
    output logic [NUM_CH*NUM_SEG-1:0] step_positive,
    output logic [NUM_CH*NUM_SEG*(SEG_W-1)-1:0] step_magnitude
);

    localparam int unsigned SEL_W = $clog2(NUM_SEG);
    localparam int unsigned CH_SEG_BITS = NUM_SEG * SEG_W;

    // All bus-side state of the slave in one record.
    typedef struct packed {
        logic wr_pend;
        logic [APS_CH_W-1:0] wr_ch;
        logic [SEL_W-1:0] wr_seg;
        logic [31:0] rdata;
        logic ready;
    } aps_bus_state_t;

    localparam aps_bus_state_t APS_BUS_RESET = '{
        wr_pend: 1'b0,
        wr_ch: '0,
        wr_seg: '0,
        rdata: APS_RDATA_RESET,
        ready: 1'b1
    };

    aps_bus_state_t state_ff;
    aps_bus_state_t nxt_state;

    // Stored values of every channel, one packed row per channel.
    logic [NUM_CH-1:0][CH_SEG_BITS-1:0] chan_vals;

    // Address-phase decode results.
    logic bus_take;
    logic [APS_IDX_W-1:0] addr_idx;
    logic [APS_CH_W-1:0] addr_ch;
    logic [3:0] addr_off;
    logic [SEL_W-1:0] addr_seg;
    logic upper_zero;
    logic ch_valid;
    logic off_valid;
    logic addr_hit;

    // Read path helpers.
    logic [CH_SEG_BITS-1:0] rd_chan;
    logic [SEG_W-1:0] rd_seg_val;
    logic fwd_hit;

    // A transfer is taken only when selected, non-idle and the bus is ready.
    // With this slave never inserting wait states, hready is a formality, but
    // honouring it keeps the block correct behind a shared interconnect.
    assign bus_take = hsel && htrans[1] && hready;

    // The word index is the byte address divided by four.
    assign addr_idx = haddr[APS_IDX_LSB +: APS_IDX_W];

    // Upper nibble of the index is the channel, lower nibble the offset.
    assign addr_ch = addr_idx[APS_IDX_W-1 -: APS_CH_W];
    assign addr_off = addr_idx[3:0];

    // Segment one sits at offset 0x08 and the other seven follow in order.
    assign addr_seg = SEL_W'(addr_off - APS_IDX_SEG_ONE[3:0]);

    // Bits above the decoded span must be zero for the access to land here.
    assign upper_zero = (haddr[31:APS_DEC_W] == '0);

    // Only fourteen channel copies exist; channels 14 and 15 are holes.
    assign ch_valid = (32'(addr_ch) < NUM_CH);

    // Offsets 0x08 to 0x0f hold segments; 0x00 to 0x07 belong elsewhere.
    assign off_valid = (addr_off >= APS_IDX_SEG_ONE[3:0]) &&
                       (addr_off <= APS_IDX_SEG_EIGHT[3:0]);

    assign addr_hit = upper_zero && ch_valid && off_valid;

    // Pick the addressed channel with a compare loop, so an index into a
    // missing channel can never select an undefined row.
    always_comb begin
        rd_chan = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (addr_ch == APS_CH_W'(c)) begin
                rd_chan = chan_vals[c];
            end
        end
    end

    // A read right behind a write to the same segment would otherwise see the
    // old value, since the write lands only at the end of its data phase.
    // Forwarding hwdata keeps read-after-write coherent at zero wait states.
    assign fwd_hit = state_ff.wr_pend &&
                     (state_ff.wr_ch == addr_ch) &&
                     (state_ff.wr_seg == addr_seg);

    always_comb begin
        rd_seg_val = rd_chan[addr_seg*SEG_W +: SEG_W];
        if (fwd_hit) begin
            rd_seg_val = hwdata[SEG_W-1:0];
        end
    end

    // Next-state logic of the slave.
    // Writes are remembered in the address phase and performed in the data
    // phase; reads are looked up in the address phase and presented from a
    // flop during the data phase. Unmapped accesses answer OKAY: reads give
    // zero and writes are dropped, which avoids bus errors on sparse maps.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.wr_pend = 1'b0;
        nxt_state.rdata = APS_RDATA_RESET;
        nxt_state.ready = 1'b1;
        if (bus_take && addr_hit) begin
            if (hwrite) begin
                nxt_state.wr_pend = 1'b1;
                nxt_state.wr_ch = addr_ch;
                nxt_state.wr_seg = addr_seg;
            end else begin
                // Bit 7 and above read as zero.
                nxt_state.rdata = {{(32-SEG_W){1'b0}}, rd_seg_val};
            end
        end
    end

    // Synchronous reset leaves the slave idle and ready.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_ff <= APS_BUS_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Read data and ready come straight from the state flops; the response is tied to OKAY.
    assign hrdata = state_ff.rdata;
    assign hreadyout = state_ff.ready;
    assign hresp = APS_HRESP_OKAY;

    // One register set per channel and one shaper behind it.
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
        logic chan_wr_en;

        // The write strobe reaches only the channel named by the address.
        assign chan_wr_en = state_ff.wr_pend && (state_ff.wr_ch == APS_CH_W'(g));

        // Only the low seven bits are stored; bit 7 of hwdata has no home.
        aps_chan_regs #(
            .NUM_SEG(NUM_SEG),
            .SEG_W(SEG_W),
            .SEL_W(SEL_W)
        ) u_regs (
            .clock(clock),
            .rst_n(rst_n),
            .wr_en(chan_wr_en),
            .wr_seg(state_ff.wr_seg),
            .wr_data(hwdata[SEG_W-1:0]),
            .seg_values(chan_vals[g])
        );

        // The shaper adds one flop of delay; the driver tolerates this
        // because segment settings change only under software control.
        aps_seg_shape #(
            .NUM_SEG(NUM_SEG),
            .SEG_W(SEG_W),
            .HALF(HALF)
        ) u_shape (
            .clock(clock),
            .rst_n(rst_n),
            .seg_values(chan_vals[g]),
            .overshoot(overshoot_level[g*SEG_W +: SEG_W]),
            .undershoot(undershoot_level[g*SEG_W +: SEG_W]),
            .upper_half(upper_half_level[g*HALF*SEG_W +: HALF*SEG_W]),
            .lower_half(lower_half_level[g*HALF*SEG_W +: HALF*SEG_W]),
            .step_positive(step_positive[g*NUM_SEG +: NUM_SEG]),
            .step_magnitude(step_magnitude[g*NUM_SEG*(SEG_W-1) +: NUM_SEG*(SEG_W-1)])
        );
    end

    // Raw values go out unchanged, already held in the channel flops.
    assign seg_level = chan_vals;

    // hsize, hburst, hprot and hmastlock carry no meaning for single word
    // accesses to this bank; narrow writes still update the seven stored bits.

endmodule : aps_pulse_seg_top

// File: testbench/aps_pulse_seg_props.sv
// Concurrent checks on the ports of the pulse segment register bank.
`timescale 1ns/1ps
module aps_pulse_seg_props
    import aps_pkg::*;
#(
    parameter int unsigned NUM_CH = APS_NUM_CH,
    parameter int unsigned NUM_SEG = APS_SEG_COUNT,
    parameter int unsigned SEG_W = APS_SEG_W,
    parameter int unsigned HALF = APS_HALF_SEGS
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Bus signals.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // Segment outputs.
    input wire logic [NUM_CH*NUM_SEG*SEG_W-1:0] seg_level,
    input wire logic [NUM_CH*SEG_W-1:0] overshoot_level,
    input wire logic [NUM_CH*SEG_W-1:0] undershoot_level,
    input wire logic [NUM_CH*HALF*SEG_W-1:0] upper_half_level,
    input wire logic [NUM_CH*HALF*SEG_W-1:0] lower_half_level,
    input wire logic [NUM_CH*NUM_SEG-1:0] step_positive,
    input wire logic [NUM_CH*NUM_SEG*(SEG_W-1)-1:0] step_magnitude
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // A transfer is taken only in a selected, ready, non-idle address phase.
    logic take;
    assign take = hsel && htrans[1] && hready;

    property p_over; overshoot_level[6:0] == $past(seg_level[6:0]); endproperty
    a_over: assert property (p_over) else $error("overshoot does not follow segment one");
    property p_under; undershoot_level[6:0] == $past(seg_level[34:28]); endproperty
    a_under: assert property (p_under) else $error("undershoot does not follow segment five");
    property p_upper; upper_half_level[27:0] == $past(seg_level[27:0]); endproperty
    a_upper: assert property (p_upper) else $error("upper half is not segments one to four");
    property p_lower; lower_half_level[27:0] == $past(seg_level[55:28]); endproperty
    a_lower: assert property (p_lower) else $error("lower half is not segments five to eight");
    property p_sign;
        step_positive[0] == $past(seg_level[6]) && step_magnitude[5:0] == $past(seg_level[5:0]);
    endproperty
    a_sign: assert property (p_sign) else $error("sign or magnitude split is wrong");
    // The write lands one edge after its data phase, so compare with hwdata of that phase.
    property p_wr;
        take && hwrite && haddr == 32'h0000_0020 ##1 1'b1 |=> seg_level[6:0] == $past(hwdata[6:0]);
    endproperty
    a_wr: assert property (p_wr) else $error("segment one did not store the written value");
    property p_rst; $rose(rst_n) |-> seg_level == '0 && hrdata == 32'h0000_0000; endproperty
    a_rst: assert property (p_rst) else $error("segments not cleared by reset");
    property p_rdval; take && !hwrite && haddr == 32'h0000_0060 |=> hrdata == 32'(seg_level[62:56]); endproperty
    a_rdval: assert property (p_rdval) else $error("channel one read returns wrong value");
    property p_unmap;
        take && !hwrite && (haddr[9:6] >= 4'he || haddr[31:10] != '0) |=> hrdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read is not zero");

    // Main scenarios reached.
    c_wr: cover property (take && hwrite);
    c_rd: cover property (take && !hwrite && haddr == 32'h0000_0060);
    c_unmap: cover property (take && !hwrite && haddr[9:6] >= 4'he);
endmodule : aps_pulse_seg_props

// File: testbench/arbitrary_pulse_segment_regs_bench.sv
// Self-checking bench for the pulse segment register bank over AHB-Lite.
`timescale 1ns/1ps
module arbitrary_pulse_segment_regs_bench;
    import aps_pkg::*;
    logic clock, rst_n, hsel, hwrite, hready, hreadyout, hresp, hmastlock;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, hburst;
    logic [3:0] hprot;
    logic [783:0] seg_level;
    logic [97:0] overshoot_level, undershoot_level;
    logic [391:0] upper_half_level, lower_half_level;
    logic [111:0] step_positive;
    logic [671:0] step_magnitude;
    logic [6:0] exp_seg [14][8];
    logic [31:0] bad_addr [4] = '{32'h0000_0000, 32'h0000_001c, 32'h0000_03a0, 32'h0000_0420};
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;

    // The only slave drives the bus ready.
    assign hready = hreadyout;

    aps_pulse_seg_top u_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hburst(hburst), .hprot(hprot),
        .hmastlock(hmastlock), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .seg_level(seg_level),
        .overshoot_level(overshoot_level), .undershoot_level(undershoot_level),
        .upper_half_level(upper_half_level), .lower_half_level(lower_half_level),
        .step_positive(step_positive), .step_magnitude(step_magnitude));

    // Free-running 100 MHz clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // A hang is cut short well above the roughly 730 cycles the run needs.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    task print_verdict();
        $display("errors %0d in %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One single transfer; address and data phases each held until hready is seen high.
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= APS_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= APS_HTRANS_IDLE;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb

    // Write then read of one word back to back. The read address phase overlaps the
    // write data phase, so the answer can only be right if the write data is forwarded.
    task ahb_wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= APS_HTRANS_NONSEQ;
        hwrite <= 1'b1;
        do @(posedge clock); while (hready !== 1'b1);
        hwrite <= 1'b0;
        hwdata <= d;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= APS_HTRANS_IDLE;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
    endtask : ahb_wr_rd

    function automatic logic [31:0] adr(int c, int s);
        return 32'(4 * (c * 16 + 8 + s));
    endfunction : adr

    // Compares every raw and shaped output with the expected segment table.
    task check_all();
        logic [6:0] e;
        for (int c = 0; c < 14; c++) begin
            for (int s = 0; s < 8; s++) begin
                e = exp_seg[c][s];
                chk(32'(seg_level[(c*8+s)*7 +: 7]), 32'(e));
                chk(32'(step_positive[c*8+s]), 32'(e[6]));
                chk(32'(step_magnitude[(c*8+s)*6 +: 6]), 32'(e[5:0]));
                if (s < 4) chk(32'(upper_half_level[c*28+s*7 +: 7]), 32'(e));
                else chk(32'(lower_half_level[c*28+(s-4)*7 +: 7]), 32'(e));
            end
            chk(32'(overshoot_level[c*7 +: 7]), 32'(exp_seg[c][0]));
            chk(32'(undershoot_level[c*7 +: 7]), 32'(exp_seg[c][4]));
        end
    endtask : check_all

    // Main sequence: reset, fill every channel, read back, unmapped, second reset.
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = APS_HTRANS_IDLE;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        hsize = 3'h2;
        hburst = 3'h0;
        hprot = 4'h3;
        hmastlock = 1'b0;
        foreach (exp_seg[c, s]) exp_seg[c][s] = 7'h00;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        check_all();
        // Bit 7 and the upper bits are set on purpose; they must be dropped.
        foreach (exp_seg[c, s]) begin
            exp_seg[c][s] = 7'((c * 8 + s) * 37 + 35);
            ahb(1'b1, adr(c, s), {25'h1ff_ffff, exp_seg[c][s]}, rd);
        end
        foreach (exp_seg[c, s]) begin
            ahb(1'b0, adr(c, s), 32'h0000_0000, rd);
            chk(rd, 32'(exp_seg[c][s]));
        end
        repeat (2) @(posedge clock);
        check_all();
        foreach (bad_addr[i]) begin
            ahb(1'b1, bad_addr[i], 32'h0000_007f, rd);
            ahb(1'b0, bad_addr[i], 32'h0000_0000, rd);
            chk(rd, 32'h0000_0000);
        end
        // A read right behind a write to the same segment sees the new value, bit 7 dropped.
        exp_seg[2][3] = 7'h5a;
        ahb_wr_rd(adr(2, 3), 32'h0000_00da, rd);
        chk(rd, 32'h0000_005a);
        // Outside a read data phase the read data returns to zero.
        @(posedge clock);
        chk(hrdata, 32'h0000_0000);
        chk(32'(hreadyout), 32'h0000_0001);
        chk(32'(hresp), 32'(APS_HRESP_OKAY));
        repeat (2) @(posedge clock);
        check_all();
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        foreach (exp_seg[c, s]) exp_seg[c][s] = 7'h00;
        repeat (2) @(posedge clock);
        check_all();
        print_verdict();
    end
endmodule : arbitrary_pulse_segment_regs_bench

bind aps_pulse_seg_top aps_pulse_seg_props #(.NUM_CH(NUM_CH), .NUM_SEG(NUM_SEG), .SEG_W(SEG_W),
    .HALF(HALF)) u_props (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .seg_level(seg_level), .overshoot_level(overshoot_level),
    .undershoot_level(undershoot_level), .upper_half_level(upper_half_level),
    .lower_half_level(lower_half_level), .step_positive(step_positive),
    .step_magnitude(step_magnitude));
